/* design/fpc_pkg.sv */
// package: register map, field layout and reset values of the flash port pad bank
package fpc_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] FPC_OFF_SUPPLY  = 8'h00;
	localparam logic [7:0] FPC_OFF_CLOCK   = 8'h04;
	localparam logic [7:0] FPC_OFF_DATA0   = 8'h08;
	localparam logic [7:0] FPC_OFF_DATA1   = 8'h0c;
	localparam logic [7:0] FPC_OFF_DATA2   = 8'h10;
	localparam logic [7:0] FPC_OFF_DATA3   = 8'h14;
	localparam logic [7:0] FPC_OFF_SELECT  = 8'h18;

	// ----------------------------------------------------------------
	// pad register fields
	// ----------------------------------------------------------------
	localparam int FPC_PADS            = 6;
	localparam int FPC_PAD_W           = 8;
	localparam int FPC_BIT_OUT_DIS     = 7;
	localparam int FPC_BIT_IN_GATE     = 6;
	localparam int FPC_DRIVE_HI        = 5;
	localparam int FPC_DRIVE_LO        = 4;
	localparam int FPC_BIT_PULL_UP     = 3;
	localparam int FPC_BIT_PULL_DOWN   = 2;
	localparam int FPC_BIT_HYST        = 1;
	localparam int FPC_BIT_EDGE_FAST   = 0;
	localparam int FPC_BIT_SUPPLY      = 0;

	// pad index: clock, data0..3, select
	localparam int FPC_IDX_CLOCK  = 0;
	localparam int FPC_IDX_SELECT = 5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic       FPC_RST_SUPPLY = 1'b0;
	localparam logic [7:0] FPC_RST_CLOCK  = 8'h56;
	localparam logic [7:0] FPC_RST_DATA   = 8'h52;
	localparam logic [7:0] FPC_RST_SELECT = 8'h5a;

	// drive codes
	localparam logic [1:0] FPC_DRV_2MA  = 2'h0;
	localparam logic [1:0] FPC_DRV_4MA  = 2'h1;
	localparam logic [1:0] FPC_DRV_8MA  = 2'h2;
	localparam logic [1:0] FPC_DRV_12MA = 2'h3;

	// bank supply level, one setting shared by all six pads
	typedef enum logic [1:0] {
		FPC_SUPPLY_3V3,
		FPC_SUPPLY_1V8
	} fpc_supply_t;

endpackage : fpc_pkg

/* design/fpc_reg_if.sv */
// interface: register write strobe and read-back data between bus slave and pad registers
`timescale 1ns/1ps
`default_nettype none
interface fpc_reg_if;
	logic        wr_en;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        hit;

	modport slave (output wr_en, output addr, output wdata, output be, input rdata, input hit);
	modport regs  (input wr_en, input addr, input wdata, input be, output rdata, output hit);
endinterface : fpc_reg_if
`default_nettype wire

/* design/fpc_bus_slave.sv */
// module: avalon-mm slave front end with one wait state per access
`timescale 1ns/1ps
`default_nettype none
module fpc_bus_slave
	import fpc_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  address_in,
	input  wire logic        read_in,
	input  wire logic        write_in,
	input  wire logic [31:0] writedata_in,
	input  wire logic [3:0]  byteenable_in,
	output logic [31:0]      readdata_out,
	output logic             waitrequest_out,
	output logic             response_err_out,
	fpc_reg_if.slave         rif
);
	// ----------------------------------------------------------------
	// access sequencing
	// ----------------------------------------------------------------
	// every access holds waitrequest high in its first cycle; the second
	// cycle drops it, so all bus-side outputs come from flip-flops
	logic busy_q;

	assign rif.addr  = address_in;
	assign rif.wdata = writedata_in;
	assign rif.be    = byteenable_in;
	assign rif.wr_en = write_in && busy_q && !read_in;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
		end else if ((read_in || write_in) && !busy_q) begin
			busy_q <= 1'b1;
		end else begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			waitrequest_out <= 1'b1;
		end else begin
			waitrequest_out <= !((read_in || write_in) && !busy_q);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			readdata_out     <= 32'h0000_0000;
			response_err_out <= 1'b0;
		end else if ((read_in || write_in) && !busy_q) begin
			readdata_out     <= read_in ? rif.rdata : 32'h0000_0000;
			response_err_out <= !rif.hit;
		end
	end
endmodule : fpc_bus_slave
`default_nettype wire

/* design/fpc_pad_bank.sv */
// module: flash port pad control bank, six pad registers plus supply level
`timescale 1ns/1ps
`default_nettype none

module fpc_pad_bank
	import fpc_pkg::*;
#(
	parameter int PADS = FPC_PADS
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rst_in,
	input  wire logic [7:0]       address_in,
	input  wire logic             read_in,
	input  wire logic             write_in,
	input  wire logic [31:0]      writedata_in,
	input  wire logic [3:0]       byteenable_in,
	output logic [31:0]           readdata_out,
	output logic                  waitrequest_out,
	output logic [1:0]            response_out,
	input  wire logic [PADS-1:0]  periph_oe_in,
	input  wire logic [PADS-1:0]  periph_out_in,
	output logic [PADS-1:0]       pad_drive_on_out,
	output logic [PADS-1:0]       pad_out_out,
	output logic [PADS-1:0]       input_gate_on_out,
	output logic [PADS*4-1:0]     pad_drive_legs_out,
	output logic [PADS-1:0]       pull_up_on_out,
	output logic [PADS-1:0]       pull_down_on_out,
	output logic [PADS-1:0]       hysteresis_on_out,
	output logic [PADS-1:0]       edge_rate_fast_out,
	output logic                  supply_1v8_out
);
	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	fpc_reg_if rif ();
	logic      err_q;

	fpc_bus_slave u_slave (
		.ref_clk_in       (ref_clk_in),
		.rst_in           (rst_in),
		.address_in       (address_in),
		.read_in          (read_in),
		.write_in         (write_in),
		.writedata_in     (writedata_in),
		.byteenable_in    (byteenable_in),
		.readdata_out     (readdata_out),
		.waitrequest_out  (waitrequest_out),
		.response_err_out (err_q),
		.rif              (rif)
	);

	// slave error on unmapped offsets; kept as a bare flop bit so the
	// response needs no decode gate on its way out
	assign response_out = {err_q, 1'b0};

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	fpc_supply_t                supply_q;
	logic [FPC_PAD_W-1:0]       pad_q [PADS];
	logic [PADS-1:0]            pad_sel;

	function automatic logic [7:0] fpc_reset_of(input int idx);
		if (idx == FPC_IDX_CLOCK) begin
			return FPC_RST_CLOCK;
		end else if (idx == FPC_IDX_SELECT) begin
			return FPC_RST_SELECT;
		end else begin
			return FPC_RST_DATA;
		end
	endfunction : fpc_reset_of

	// supply-level register: one bit, everything above reads zero
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			supply_q <= FPC_SUPPLY_3V3;
		end else if (rif.wr_en && rif.addr == FPC_OFF_SUPPLY && rif.be[0]) begin
			supply_q <= fpc_supply_t'(rif.wdata[FPC_BIT_SUPPLY]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < PADS; g++) begin : g_pad
			// pads sit one word apart starting at the clock pad
			assign pad_sel[g] = (rif.addr == 8'(FPC_OFF_CLOCK + 4 * g));

			always_ff @(posedge ref_clk_in) begin
				if (rst_in) begin
					pad_q[g] <= fpc_reset_of(g);
				end else if (rif.wr_en && pad_sel[g] && rif.be[0]) begin
					// only the low byte is stored; upper lanes are dropped
					pad_q[g] <= rif.wdata[FPC_PAD_W-1:0];
				end
			end

			// pad cell controls, registered so every output is a flop
			always_ff @(posedge ref_clk_in) begin
				if (rst_in) begin
					pad_drive_on_out[g] <= 1'b0;
					pad_out_out[g]      <= 1'b0;
				end else begin
					// output disable outranks the peripheral's enable
					pad_drive_on_out[g] <= periph_oe_in[g] && !pad_q[g][FPC_BIT_OUT_DIS];
					pad_out_out[g]      <= periph_out_in[g];
				end
			end

			always_ff @(posedge ref_clk_in) begin
				if (rst_in) begin
					input_gate_on_out[g]    <= 1'b0;
					pad_drive_legs_out[g*4 +: 4] <= 4'h0;
					pull_up_on_out[g]       <= 1'b0;
					pull_down_on_out[g]     <= 1'b0;
					hysteresis_on_out[g]    <= 1'b0;
					edge_rate_fast_out[g]   <= 1'b0;
				end else begin
					input_gate_on_out[g]  <= pad_q[g][FPC_BIT_IN_GATE];
					case (pad_q[g][FPC_DRIVE_HI:FPC_DRIVE_LO])
						FPC_DRV_2MA:  pad_drive_legs_out[g*4 +: 4] <= 4'h1;
						FPC_DRV_4MA:  pad_drive_legs_out[g*4 +: 4] <= 4'h2;
						FPC_DRV_8MA:  pad_drive_legs_out[g*4 +: 4] <= 4'h4;
						FPC_DRV_12MA: pad_drive_legs_out[g*4 +: 4] <= 4'h8;
						default:      pad_drive_legs_out[g*4 +: 4] <= 4'h1;
					endcase
					pull_up_on_out[g]     <= pad_q[g][FPC_BIT_PULL_UP];
					pull_down_on_out[g]   <= pad_q[g][FPC_BIT_PULL_DOWN];
					hysteresis_on_out[g]  <= pad_q[g][FPC_BIT_HYST];
					edge_rate_fast_out[g] <= pad_q[g][FPC_BIT_EDGE_FAST];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			supply_1v8_out <= 1'b0;
		end else begin
			supply_1v8_out <= (supply_q == FPC_SUPPLY_1V8);
		end
	end

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	always_comb begin
		rif.rdata = 32'h0000_0000;
		rif.hit   = 1'b0;
		if (rif.addr == FPC_OFF_SUPPLY) begin
			rif.rdata = {31'h0000_0000, supply_q == FPC_SUPPLY_1V8};
			rif.hit   = 1'b1;
		end else begin
			for (int i = 0; i < PADS; i++) begin
				if (pad_sel[i]) begin
					rif.rdata = {24'h00_0000, pad_q[i]};
					rif.hit   = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	a_disable_blocks_drive: assert property (
		pad_q[3][FPC_BIT_OUT_DIS] |=> !pad_drive_on_out[3])
		else $error("data2 pad driven while output disabled");

	a_enable_drives_pad: assert property (
		(!pad_q[1][FPC_BIT_OUT_DIS] && periph_oe_in[1]) |=> pad_drive_on_out[1])
		else $error("data0 pad not driven though enabled");

	a_drive_12ma_leg: assert property (
		(pad_q[4][FPC_DRIVE_HI:FPC_DRIVE_LO] == FPC_DRV_12MA) |=> pad_drive_legs_out[19:16] == 4'h8)
		else $error("12 mA code not decoded");

	a_drive_2ma_leg: assert property (
		(pad_q[1][FPC_DRIVE_HI:FPC_DRIVE_LO] == FPC_DRV_2MA) |=> pad_drive_legs_out[7:4] == 4'h1)
		else $error("2 mA code not decoded");

	a_supply_write: assert property (
		(rif.wr_en && rif.addr == FPC_OFF_SUPPLY && rif.be[0])
		|=> ##1 supply_1v8_out == $past(rif.wdata[0], 2))
		else $error("supply level not following write");

	a_edge_rate_follow: assert property (
		(rif.wr_en && pad_sel[4] && rif.be[0])
		|=> ##1 edge_rate_fast_out[4] == $past(rif.wdata[0], 2))
		else $error("edge rate not following write");

	a_data_sel_offset: assert property (
		(rif.addr == FPC_OFF_DATA3) |-> pad_sel == 6'h10)
		else $error("data3 offset decoded wrongly");

	a_reserved_zero: assert property (
		(read_in && !waitrequest_out) |-> readdata_out[31:8] == 24'h00_0000)
		else $error("reserved read bits not zero");

	// ----------------------------------------------------------------
	// bus timing and decode checks
	// ----------------------------------------------------------------
	// software polls nothing else, so exactly one wait state is the whole
	// handshake; a second one would move the write strobe off its edge
	a_wait_then_go: assert property (
		((read_in || write_in) && waitrequest_out) |=> !waitrequest_out)
		else $error("access not answered after one wait state");

	a_wait_one_low: assert property (
		!waitrequest_out |=> waitrequest_out)
		else $error("waitrequest low for more than one cycle");

	a_idle_quiet: assert property (
		(!read_in && !write_in && waitrequest_out) |=> waitrequest_out)
		else $error("waitrequest dropped with no access");

	a_unmapped_err: assert property (
		((read_in || write_in) && waitrequest_out && address_in > FPC_OFF_SELECT)
		|=> response_out == 2'h2)
		else $error("unmapped offset not flagged");

	a_mapped_okay: assert property (
		((read_in || write_in) && waitrequest_out && address_in == FPC_OFF_DATA1)
		|=> response_out == 2'h0)
		else $error("mapped offset flagged as an error");

	a_supply_hold: assert property (
		!(rif.wr_en && rif.addr == FPC_OFF_SUPPLY && rif.be[0]) |=> $stable(supply_q))
		else $error("supply level changed without a write");

	a_supply_read: assert property (
		(read_in && waitrequest_out && address_in == FPC_OFF_SUPPLY)
		|=> readdata_out[31:1] == 31'h0000_0000
			&& readdata_out[0] == $past(supply_q == FPC_SUPPLY_1V8))
		else $error("supply level read back wrongly");

	// ----------------------------------------------------------------
	// per-pad checks
	// ----------------------------------------------------------------
	// one copy per pad, so a slip in a single pad's index or layout
	// cannot hide behind the spot checks above
	genvar k;
	generate
		for (k = 0; k < PADS; k++) begin : g_pad_chk
			a_disable_each_pad: assert property (
				pad_q[k][FPC_BIT_OUT_DIS] |=> !pad_drive_on_out[k])
				else $error("pad driven while output disabled");

			a_enable_each_pad: assert property (
				(!pad_q[k][FPC_BIT_OUT_DIS] && periph_oe_in[k]) |=> pad_drive_on_out[k])
				else $error("pad not driven though enabled");

			a_idle_each_pad: assert property (
				!periph_oe_in[k] |=> !pad_drive_on_out[k])
				else $error("pad driven without a peripheral enable");

			a_value_each_pad: assert property (
				1'b1 |=> pad_out_out[k] == $past(periph_out_in[k]))
				else $error("pad output value not passed through");

			a_legs_each_pad: assert property (
				1'b1 |=> pad_drive_legs_out[k*4 +: 4]
					== 4'h1 << $past(pad_q[k][FPC_DRIVE_HI:FPC_DRIVE_LO]))
				else $error("drive legs do not match the drive code");

			a_edge_each_pad: assert property (
				1'b1 |=> edge_rate_fast_out[k] == $past(pad_q[k][FPC_BIT_EDGE_FAST]))
				else $error("edge rate control not following its bit");

			a_pulls_each_pad: assert property (
				1'b1 |=> pull_up_on_out[k] == $past(pad_q[k][FPC_BIT_PULL_UP])
					&& pull_down_on_out[k] == $past(pad_q[k][FPC_BIT_PULL_DOWN]))
				else $error("pull controls not following their bits");

			a_gate_each_pad: assert property (
				1'b1 |=> input_gate_on_out[k] == $past(pad_q[k][FPC_BIT_IN_GATE])
					&& hysteresis_on_out[k] == $past(pad_q[k][FPC_BIT_HYST]))
				else $error("input gate or hysteresis not following their bits");

			a_store_each_pad: assert property (
				(rif.wr_en && pad_sel[k] && rif.be[0])
				|=> pad_q[k] == $past(rif.wdata[FPC_PAD_W-1:0]))
				else $error("pad register not holding the written low byte");

			a_lane_each_pad: assert property (
				(rif.wr_en && pad_sel[k] && !rif.be[0]) |=> $stable(pad_q[k]))
				else $error("pad register written without its byte lane");
		end
	endgenerate

	c_write_pad: cover property (write_in && !waitrequest_out && address_in == FPC_OFF_DATA0);
	c_read_pad: cover property (read_in && !waitrequest_out && address_in == FPC_OFF_SELECT);
	c_unmapped: cover property (read_in && !waitrequest_out && err_q);
	c_supply_1v8: cover property (supply_1v8_out);
	c_drive_blocked: cover property (pad_q[3][FPC_BIT_OUT_DIS] && periph_oe_in[3]);
endmodule : fpc_pad_bank
`default_nettype wire

/* bench/tb_top.sv */
// testbench: register and pad output checks of the flash port pad bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fpc_pkg::*;
;
	// ----------------------------------------------------------------
	// clock, reset and design hookup
	// ----------------------------------------------------------------
	logic        ref_clk_in;
	logic        rst_in;
	logic [7:0]  address_in;
	logic        read_in;
	logic        write_in;
	logic [31:0] writedata_in;
	logic [3:0]  byteenable_in;
	logic [31:0] readdata_out;
	logic        waitrequest_out;
	logic [1:0]  response_out;
	logic [5:0]  periph_oe_in;
	logic [5:0]  periph_out_in;
	logic [5:0]  pad_drive_on_out;
	logic [5:0]  pad_out_out;
	logic [5:0]  input_gate_on_out;
	logic [23:0] pad_drive_legs_out;
	logic [5:0]  pull_up_on_out;
	logic [5:0]  pull_down_on_out;
	logic [5:0]  hysteresis_on_out;
	logic [5:0]  edge_rate_fast_out;
	logic        supply_1v8_out;
	int          err_count;
	int          n_tests;
	logic [31:0] rd_q;
	logic [1:0]  rsp_q;
	logic [31:0] rst_tab [7];

	fpc_pad_bank #(.PADS(6)) dut (
		.ref_clk_in         (ref_clk_in),
		.rst_in             (rst_in),
		.address_in         (address_in),
		.read_in            (read_in),
		.write_in           (write_in),
		.writedata_in       (writedata_in),
		.byteenable_in      (byteenable_in),
		.readdata_out       (readdata_out),
		.waitrequest_out    (waitrequest_out),
		.response_out       (response_out),
		.periph_oe_in       (periph_oe_in),
		.periph_out_in      (periph_out_in),
		.pad_drive_on_out   (pad_drive_on_out),
		.pad_out_out        (pad_out_out),
		.input_gate_on_out  (input_gate_on_out),
		.pad_drive_legs_out (pad_drive_legs_out),
		.pull_up_on_out     (pull_up_on_out),
		.pull_down_on_out   (pull_down_on_out),
		.hysteresis_on_out  (hysteresis_on_out),
		.edge_rate_fast_out (edge_rate_fast_out),
		.supply_1v8_out     (supply_1v8_out)
	);

	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	// ----------------------------------------------------------------
	// bus access and compare tasks
	// ----------------------------------------------------------------
	// entered just after a rising edge; holds the request until waitrequest is seen low
	task automatic bus_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address_in   <= a;
		writedata_in <= d;
		write_in     <= wr;
		read_in      <= ~wr;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (waitrequest_out !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("MISMATCH %0t no answer on the bus", $time);
		end
		rd_q  = readdata_out;
		rsp_q = response_out;
		read_in  <= 1'b0;
		write_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask : bus_acc

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t register read %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	// pad outputs are looked at mid-cycle, then the bench realigns to the rising edge
	task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t pad output %h expected %h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#(2000 * 50);
		err_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		n_tests = 0;
		rst_in = 1'b1;
		address_in = 8'h00;
		read_in = 1'b0;
		write_in = 1'b0;
		writedata_in = 32'h0000_0000;
		byteenable_in = 4'hf;
		periph_oe_in = 6'h3f;
		periph_out_in = 6'h15;
		// reset layouts: supply, clock pad, four data pads, select pad
		rst_tab = '{32'h0000_0000, 32'h0000_0056, 32'h0000_0052, 32'h0000_0052,
			32'h0000_0052, 32'h0000_0052, 32'h0000_005a};
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		for (int i = 0; i < 7; i++) begin
			bus_acc(1'b0, 8'(4 * i), 32'h0000_0000);
			chk_reg(rd_q, rst_tab[i]);
		end
		@(negedge ref_clk_in);
		chk_pin({18'h0, pull_up_on_out | pull_down_on_out} & 24'h0000_1e, 24'h0);
		chk_pin({18'h0, edge_rate_fast_out}, 24'h0);
		chk_pin({18'h0, pad_drive_on_out}, 24'h0000_3f);
		chk_pin({23'h0, supply_1v8_out}, 24'h0);
		chk_pin({18'h0, pull_up_on_out}, 24'h0000_20);
		chk_pin({18'h0, pull_down_on_out}, 24'h0000_01);
		chk_pin({18'h0, input_gate_on_out & hysteresis_on_out}, 24'h0000_3f);
		chk_pin(pad_drive_legs_out, 24'h22_2222);
		chk_pin({18'h0, pad_out_out}, 24'h0000_15);
		@(posedge ref_clk_in);
		// supply level, with reserved bits written high
		bus_acc(1'b1, 8'h00, 32'hffff_ffff);
		bus_acc(1'b0, 8'h00, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_0001);
		@(negedge ref_clk_in);
		chk_pin({23'h0, supply_1v8_out}, 24'h1);
		@(posedge ref_clk_in);
		// every drive code on the data0 pad
		for (int c = 0; c < 4; c++) begin
			bus_acc(1'b1, 8'h08, 32'h0000_0042 | (32'(c) << 4));
			@(negedge ref_clk_in);
			chk_pin({20'h0, pad_drive_legs_out[7:4]}, 24'(4'h1 << c));
			@(posedge ref_clk_in);
		end
		// a write without the low byte lane leaves the pad register alone
		byteenable_in <= 4'he;
		bus_acc(1'b1, 8'h0c, 32'hffff_ffff);
		byteenable_in <= 4'hf;
		bus_acc(1'b0, 8'h0c, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_0052);
		chk_reg({30'h0, rsp_q}, 32'h0000_0000);
		// output disable on data2 overrides the peripheral enable
		bus_acc(1'b1, 8'h10, 32'h0000_00d2);
		@(negedge ref_clk_in);
		chk_pin({18'h0, pad_drive_on_out}, 24'h0000_37);
		@(posedge ref_clk_in);
		// fast edges on the select pad, reserved bits of data3
		bus_acc(1'b1, 8'h18, 32'h0000_005b);
		bus_acc(1'b1, 8'h14, 32'hffff_ffff);
		bus_acc(1'b0, 8'h14, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_00ff);
		@(negedge ref_clk_in);
		chk_pin({18'h0, edge_rate_fast_out}, 24'h0000_30);
		chk_pin({18'h0, pad_drive_on_out}, 24'h0000_27);
		@(posedge ref_clk_in);
		// peripheral enables and values follow one cycle later
		periph_oe_in  <= 6'h0a;
		periph_out_in <= 6'h2a;
		@(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk_pin({18'h0, pad_drive_on_out}, 24'h0000_02);
		chk_pin({18'h0, pad_out_out}, 24'h0000_2a);
		@(posedge ref_clk_in);
		bus_acc(1'b0, 8'h1c, 32'h0000_0000);
		chk_reg({rd_q[31:2], rsp_q}, 32'h0000_0002);
		// a second reset in mid-run restores data3, the supply, every edge rate and data2's output disable
		rst_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		bus_acc(1'b0, 8'h14, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_0052);
		bus_acc(1'b0, 8'h00, 32'h0000_0000);
		chk_reg(rd_q, 32'h0000_0000);
		@(negedge ref_clk_in);
		chk_pin({18'h0, edge_rate_fast_out}, 24'h0);
		chk_pin({23'h0, supply_1v8_out}, 24'h0);
		chk_pin({18'h0, pad_drive_on_out}, 24'h0000_0a);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
